// ---- hdl/pvc_dds.sv ----
`timescale 1ns/10ps
`default_nettype none
module pvc_dds #(
  parameter int IW = 16,
  parameter int LW = 24
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [IW-1:0] inc,
  input wire logic [LW-1:0] lim,
  output logic tick
);
  logic [LW-1:0] acc_r;
  logic tick_r;
  wire [LW:0] sum = {1'b0, acc_r} + {{(LW+1-IW){1'b0}}, inc};
  wire wrap = (sum >= {1'b0, lim});
  // Phase accumulator: the tick rate is clk * inc / lim, so the
  // fractional remainder carries over and keeps long-term jitter low.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_r <= '0;
      tick_r <= 1'b0;
    end else if (!run || lim == '0) begin
      acc_r <= '0;
      tick_r <= 1'b0;
    end else begin
      acc_r <= wrap ? LW'(sum - {1'b0, lim}) : LW'(sum);
      tick_r <= wrap;
    end
  end
  assign tick = tick_r;
endmodule : pvc_dds
`default_nettype wire

// ---- hdl/pvc_pkg.sv ----
package pvc_pkg;
  localparam int ADR_W = 8;
  localparam logic [7:0] ADR_CFG = 8'h00;
  localparam logic [7:0] ADR_SYN = 8'h04;
  localparam logic [7:0] ADR_GAIN = 8'h08;
  localparam logic [7:0] ADR_TX = 8'h0c;
  localparam logic [7:0] ADR_RX = 8'h10;
  localparam logic [7:0] ADR_STAT = 8'h14;
  localparam logic [31:0] CFG_RST = 32'h0080_0000;
  localparam logic [31:0] CFG_MASK = 32'h1fe0_1ff6;
  localparam logic [31:0] SYN_RST = 32'h0808_0177;
  localparam logic [31:0] SYN_MASK = 32'hffff_1fff;
  localparam int B_SLAVE = 1;
  localparam int B_SHORT = 2;
  localparam int B_SIGNX = 4;
  localparam int B_LSB = 5;
  localparam int B_REL = 6;
  localparam int B_LATE = 7;
  localparam int B_HOLD = 8;
  localparam int B_ISDN = 9;
  localparam int B_MUTE = 10;
  localparam int B_HI = 11;
  localparam int B_LONG16 = 12;
  localparam int F_RATE_LO = 21;
  localparam int F_SLOT_LO = 23;
  localparam int F_FMT_LO = 27;
  localparam int F_CEIL_LO = 0;
  localparam int F_CEIL_W = 13;
  localparam int F_INC_LO = 16;
  localparam int F_SDIV_LO = 24;
  localparam logic [1:0] RATE_128 = 2'h1;
  localparam logic [1:0] RATE_512 = 2'h2;
  localparam logic [1:0] FMT_13 = 2'h0;
  localparam logic [1:0] FMT_16 = 2'h1;
  localparam logic [1:0] FMT_8 = 2'h2;
  localparam logic [15:0] KHZ_128 = 16'h0080;
  localparam logic [15:0] KHZ_256 = 16'h0100;
  localparam logic [15:0] KHZ_512 = 16'h0200;
  localparam logic [15:0] FRAME_KHZ = 16'h0008;
  localparam int SYS_MHZ = 125;
  localparam int HI_SRC_MHZ = 48;
  localparam logic [7:0] SYNC_LONG = 8'h08;
  localparam logic [7:0] SYNC_LONG16 = 8'h10;
  localparam int SDIV_MULT = 8;
  localparam logic [7:0] POS_IDLE = 8'hff;
  localparam logic [2:0] GAIN_RST = 3'h0;
endpackage : pvc_pkg

// ---- hdl/pvc_port.sv ----
// Overview of operation
// - Main configuration word resets to 0x00800000.
// - Bit 1 selects master or slave role.
// - Bit 2 selects long or short sync outside ISDN timing.
// - Bit 4 selects padding or sign extension.
// - Padding carries gain or zeros.
// - Bit 5 selects MSB or LSB first.
// - Bit 6 releases output after active slots.
// - Bit 7 moves release to rising edge.
// - Bit 8 holds master sync low.
// - Bit 10 mutes serial output to zero.
// - Bit 11 selects 4 or 48 MHz source.
// - Bit 12 makes long sync 16 cycles with the 48 MHz source.
// - Field 22:21 picks 128, 256, 512 kHz.
// - Slot field stored, value otherwise ignored.
// - Field 28:27 picks sample format and slot.
// - Second word 12:0 holds synth ceiling.
// - Second word 23:16 holds synth increment.
// - Second word 31:24 holds sync divider.
// - Bit clock is increment/ceiling times 24 MHz.
// - Sync rate is bit clock over 8*divider.
// - ISDN timing carries two 8-bit channels.
`timescale 1ns/10ps
`default_nettype none
module pvc_port (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [pvc_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic pcm_clk_i,
  output logic pcm_clk_o,
  output logic pcm_clk_oe_n,
  input wire logic pcm_sync_i,
  output logic pcm_sync_o,
  output logic pcm_sync_oe_n,
  input wire logic pcm_in,
  output logic pcm_out,
  output logic pcm_out_oe_n
);
  logic [31:0] cfg_r;
  logic [31:0] syn_r;
  logic [2:0] gain_r;
  logic [15:0] tx_r;
  logic [15:0] tx_lat_r;
  logic [15:0] rx_r;
  logic [15:0] rx_sh_r;
  logic [31:0] dat_r;
  logic ack_r;
  logic bclk_r;
  logic msync_r;
  logic [11:0] mcnt_r;
  logic sync_last_r;
  logic [7:0] pos_r;
  logic dout_r;
  logic oe_n_r;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        m[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return m;
  endfunction : merge

  function automatic logic [15:0] build_slot(input logic [15:0] s, input logic [1:0] fmt,
                                             input logic sx, input logic [2:0] g);
    logic [15:0] w;
    w = 16'h0000;
    case (fmt)
      pvc_pkg::FMT_13: w = sx ? {{3{s[12]}}, s[12:0]} : {s[12:0], g};
      pvc_pkg::FMT_16: w = s;
      pvc_pkg::FMT_8: w = sx ? {{8{s[7]}}, s[7:0]} : {s[7:0], 8'h00};
      default: w = {s[7:0], 8'h00};
    endcase
    return w;
  endfunction : build_slot

  // Slot 0 is always active; the second channel is active only in ISDN timing.
  function automatic logic slot_on(input logic [8:0] p, input logic s8, input logic isdn);
    logic [8:0] idx;
    idx = s8 ? (p >> 3) : (p >> 4);
    return (idx == 9'h000) || (isdn && idx == 9'h001);
  endfunction : slot_on

  // Configuration fields.
  wire slave = cfg_r[pvc_pkg::B_SLAVE];
  wire short_s = cfg_r[pvc_pkg::B_SHORT];
  wire signx = cfg_r[pvc_pkg::B_SIGNX];
  wire lsb_first = cfg_r[pvc_pkg::B_LSB];
  wire output_release_enable = cfg_r[pvc_pkg::B_REL];
  wire output_release_late_edge = cfg_r[pvc_pkg::B_LATE];
  wire frame_pulse_hold_low = cfg_r[pvc_pkg::B_HOLD];
  wire isdn_timing_select = cfg_r[pvc_pkg::B_ISDN];
  wire mute = cfg_r[pvc_pkg::B_MUTE];
  wire high_rate_synth_select = cfg_r[pvc_pkg::B_HI];
  wire long16 = cfg_r[pvc_pkg::B_LONG16];
  wire [1:0] rate = cfg_r[pvc_pkg::F_RATE_LO +: 2];
  wire [1:0] fmt = cfg_r[pvc_pkg::F_FMT_LO +: 2];
  wire [12:0] synth_counter_ceiling = syn_r[pvc_pkg::F_CEIL_LO +: pvc_pkg::F_CEIL_W];
  wire [7:0] synth_increment = syn_r[pvc_pkg::F_INC_LO +: 8];
  wire [7:0] sync_div = syn_r[pvc_pkg::F_SDIV_LO +: 8];

  // Register bus: one wait state, ack for one cycle, writes on the ack edge.
  wire hit = wb_cyc_i & wb_stb_i;
  wire wr = hit & ack_r & wb_we_i;
  wire [31:0] wmerged_cfg = merge(cfg_r, wb_dat_i, wb_sel_i);
  wire [31:0] wmerged_syn = merge(syn_r, wb_dat_i, wb_sel_i);
  wire [31:0] wmerged_low = merge({16'h0000, tx_r}, wb_dat_i, wb_sel_i);
  wire [31:0] stat = {21'h000000, slave, msync_r, ~oe_n_r, pos_r};
  wire [31:0] rd_val =
    (wb_adr_i == pvc_pkg::ADR_CFG) ? cfg_r :
    (wb_adr_i == pvc_pkg::ADR_SYN) ? syn_r :
    (wb_adr_i == pvc_pkg::ADR_GAIN) ? {29'h00000000, gain_r} :
    (wb_adr_i == pvc_pkg::ADR_TX) ? {16'h0000, tx_r} :
    (wb_adr_i == pvc_pkg::ADR_RX) ? {16'h0000, rx_r} :
    (wb_adr_i == pvc_pkg::ADR_STAT) ? stat : 32'h0000_0000;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
      cfg_r <= pvc_pkg::CFG_RST;
      syn_r <= pvc_pkg::SYN_RST;
      gain_r <= pvc_pkg::GAIN_RST;
      tx_r <= 16'h0000;
    end else begin
      ack_r <= hit & ~ack_r;
      if (hit && !ack_r) begin
        dat_r <= rd_val;
      end
      if (wr && wb_adr_i == pvc_pkg::ADR_CFG) begin
        cfg_r <= wmerged_cfg & pvc_pkg::CFG_MASK;
      end
      if (wr && wb_adr_i == pvc_pkg::ADR_SYN) begin
        syn_r <= wmerged_syn & pvc_pkg::SYN_MASK;
      end
      if (wr && wb_adr_i == pvc_pkg::ADR_GAIN && wb_sel_i[0]) begin
        gain_r <= wb_dat_i[2:0];
      end
      if (wr && wb_adr_i == pvc_pkg::ADR_TX) begin
        tx_r <= wmerged_low[15:0];
      end
    end
  end
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // Master clock synthesis. The accumulator ticks at twice the bit clock.
  wire [15:0] lo_khz = (rate == pvc_pkg::RATE_128) ? pvc_pkg::KHZ_128 :
                       (rate == pvc_pkg::RATE_512) ? pvc_pkg::KHZ_512 :
                       pvc_pkg::KHZ_256;
  wire [15:0] dds_inc = high_rate_synth_select ?
                        16'(synth_increment * pvc_pkg::HI_SRC_MHZ) :
                        16'({lo_khz, 1'b0});
  wire [23:0] dds_lim = high_rate_synth_select ?
                        24'(synth_counter_ceiling * pvc_pkg::SYS_MHZ) :
                        24'(pvc_pkg::SYS_MHZ * 1000);
  wire [11:0] frame_len = high_rate_synth_select ?
                          12'(sync_div * pvc_pkg::SDIV_MULT) :
                          12'(lo_khz / pvc_pkg::FRAME_KHZ);
  wire [7:0] sync_len = (high_rate_synth_select && long16) ?
                        pvc_pkg::SYNC_LONG16 : pvc_pkg::SYNC_LONG;
  wire tick;

  pvc_dds #(.IW(16), .LW(24)) u_dds (
    .clk(clk),
    .rst_n(rst_n),
    .run(~slave),
    .inc(dds_inc),
    .lim(dds_lim),
    .tick(tick)
  );

  wire m_rise = tick & ~bclk_r;
  wire m_fall = tick & bclk_r;
  wire [11:0] mcnt_nxt = (12'(mcnt_r + 12'h001) >= frame_len) ? 12'h000 :
                         12'(mcnt_r + 12'h001);
  wire short_mode = short_s & ~isdn_timing_select;
  // Sync changes on the falling bit clock edge so that it is settled at the
  // next rising edge, where the frame start is judged.
  wire msync_nxt = frame_pulse_hold_low ? 1'b0 :
                   short_mode ? (mcnt_nxt == 12'(frame_len - 12'h001)) :
                   (mcnt_nxt < {4'h0, sync_len});

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bclk_r <= 1'b0;
      mcnt_r <= 12'h000;
      msync_r <= 1'b0;
    end else begin
      if (tick) begin
        bclk_r <= ~bclk_r;
      end
      if (m_fall) begin
        mcnt_r <= mcnt_nxt;
        msync_r <= msync_nxt;
      end
    end
  end
  assign pcm_clk_o = bclk_r;
  assign pcm_sync_o = msync_r;
  assign pcm_clk_oe_n = slave;
  assign pcm_sync_oe_n = slave;

  // Slave inputs and serial data input all arrive from outside this clock.
  wire c_lvl;
  wire c_rise;
  wire c_fall;
  wire s_lvl;
  wire din;

  pvc_sync_in u_clk_in (
    .clk(clk),
    .rst_n(rst_n),
    .pin(pcm_clk_i),
    .lvl(c_lvl),
    .rise(c_rise),
    .fall(c_fall)
  );

  pvc_sync_in u_sync_in (
    .clk(clk),
    .rst_n(rst_n),
    .pin(pcm_sync_i),
    .lvl(s_lvl),
    .rise(),
    .fall()
  );

  pvc_sync_in u_data_in (
    .clk(clk),
    .rst_n(rst_n),
    .pin(pcm_in),
    .lvl(din),
    .rise(),
    .fall()
  );

  // Bit engine, common to both roles.
  wire rise_ev = slave ? c_rise : m_rise;
  wire fall_ev = slave ? c_fall : m_fall;
  wire sync_now = slave ? s_lvl : msync_r;
  wire start = short_mode ? (~sync_now & sync_last_r) : (sync_now & ~sync_last_r);
  wire [7:0] pos_nxt = start ? 8'h00 : (pos_r == pvc_pkg::POS_IDLE) ? pos_r :
                       8'(pos_r + 8'h01);
  wire s8 = (fmt == 2'h3) | isdn_timing_select;
  wire [3:0] lenm1 = s8 ? 4'h7 : 4'hf;
  wire [3:0] bis_nxt = pos_nxt[3:0] & lenm1;
  wire [3:0] bis = pos_r[3:0] & lenm1;
  wire [3:0] k_nxt = lsb_first ? 4'(lenm1 - bis_nxt) : bis_nxt;
  wire [3:0] k = lsb_first ? 4'(lenm1 - bis) : bis;
  wire on_nxt = slot_on({1'b0, pos_nxt}, s8, isdn_timing_select);
  wire on_cur = slot_on({1'b0, pos_r}, s8, isdn_timing_select);
  wire on_after = slot_on(9'({1'b0, pos_r} + 9'h001), s8, isdn_timing_select);
  wire second = isdn_timing_select & pos_nxt[3];
  wire [15:0] tx_src = start ? tx_r : tx_lat_r;
  wire [15:0] word = isdn_timing_select ?
                     (second ? {tx_src[7:0], 8'h00} : {tx_src[15:8], 8'h00}) :
                     build_slot(tx_src, fmt, signx, gain_r);
  wire pick = word[4'(4'hf - k_nxt)];
  wire last_bit = on_cur & (bis == lenm1);
  wire [15:0] rx_done = rx_sh_r | (16'({15'h0000, din}) << 4'(4'hf - k));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_last_r <= 1'b0;
      pos_r <= pvc_pkg::POS_IDLE;
      tx_lat_r <= 16'h0000;
      dout_r <= 1'b0;
      oe_n_r <= 1'b0;
      rx_sh_r <= 16'h0000;
      rx_r <= 16'h0000;
    end else begin
      if (rise_ev) begin
        sync_last_r <= sync_now;
        pos_r <= pos_nxt;
        if (start) begin
          tx_lat_r <= tx_r;
        end
        dout_r <= on_nxt & ~mute & pick;
        // Late release waits for the rising edge after the slot's last bit.
        oe_n_r <= output_release_enable & ~on_nxt & (output_release_late_edge | oe_n_r);
      end
      if (fall_ev) begin
        if (output_release_enable && !output_release_late_edge &&
            ((last_bit && !on_after) || !on_cur)) begin
          oe_n_r <= 1'b1;
        end
        if (on_cur) begin
          rx_sh_r <= last_bit ? 16'h0000 : rx_done;
        end
        if (last_bit) begin
          rx_r <= !isdn_timing_select ? rx_done :
                  pos_r[3] ? {rx_r[15:8], rx_done[15:8]} :
                  {rx_done[15:8], rx_r[7:0]};
        end
      end
    end
  end
  assign pcm_out = dout_r;
  assign pcm_out_oe_n = oe_n_r;
endmodule : pvc_port
`default_nettype wire

// ---- hdl/pvc_sync_in.sv ----
`timescale 1ns/10ps
`default_nettype none
module pvc_sync_in (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  output logic lvl,
  output logic rise,
  output logic fall
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic lvl_r;
  logic rise_r;
  logic fall_r;
  wire agree = (s2_r == s3_r);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      lvl_r <= 1'b0;
      rise_r <= 1'b0;
      fall_r <= 1'b0;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // A change counts only once the last two stages agree.
      if (agree) begin
        lvl_r <= s3_r;
      end
      rise_r <= agree & s3_r & ~lvl_r;
      fall_r <= agree & ~s3_r & lvl_r;
    end
  end
  assign lvl = lvl_r;
  assign rise = rise_r;
  assign fall = fall_r;
endmodule : pvc_sync_in
`default_nettype wire

// ---- tb/pvc_codec.sv ----
`timescale 1ns/10ps
`default_nettype none
module pvc_codec (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slave_mode,
  input wire logic short_mode,
  input wire logic [15:0] pat,
  input wire logic dut_clk,
  input wire logic dut_sync,
  input wire logic dut_out,
  input wire logic dut_out_oe_n,
  output logic bclk_o,
  output logic sync_o,
  output logic din_o,
  output logic [15:0] word_o,
  output logic [7:0] frames_o
);
  logic [4:0] div_r;
  logic [4:0] b_r;
  logic last_r;
  logic sprev_r;
  int cnt;
  int c;
  wire logic bclk = slave_mode ? bclk_o : dut_clk;
  wire logic fsync = slave_mode ? sync_o : dut_sync;
  // A released line shows the inverse of the last driven bit, never a stale copy.
  wire logic line = dut_out_oe_n ? ~last_r : dut_out;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= 5'h00;
      bclk_o <= 1'b0;
      last_r <= 1'b0;
    end else begin
      if (slave_mode) div_r <= div_r + 5'h01;
      if (slave_mode && div_r == 5'h1f) bclk_o <= ~bclk_o;
      if (!dut_out_oe_n) last_r <= dut_out;
    end
  end
  always @(posedge bclk_o or negedge rst_n) begin
    if (!rst_n) b_r <= 5'h00;
    else b_r <= b_r + 5'h01;
  end
  always @(negedge bclk_o or negedge rst_n) begin
    if (!rst_n) sync_o <= 1'b0;
    else sync_o <= short_mode ? b_r == 5'h1e : (b_r == 5'h1f || b_r < 5'h07);
  end
  always @(posedge bclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 40;
      sprev_r <= 1'b0;
      din_o <= 1'b0;
      frames_o <= 8'h00;
    end else begin
      c = (fsync != sprev_r && fsync != short_mode) ? 0 : (cnt < 40 ? cnt + 1 : cnt);
      sprev_r <= fsync;
      cnt <= c;
      din_o <= c < 16 ? pat[15 - c] : ~din_o;
      if (c == 16) frames_o <= frames_o + 8'h01;
    end
  end
  always @(negedge bclk) begin
    if (cnt < 16) word_o <= {word_o[14:0], line};
  end
endmodule : pvc_codec
`default_nettype wire

// ---- tb/pvc_port_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
module pvc_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [pvc_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic pcm_clk_o,
  input wire logic pcm_clk_oe_n,
  input wire logic pcm_sync_o,
  input wire logic pcm_sync_oe_n,
  input wire logic pcm_out,
  input wire logic pcm_out_oe_n
);
  logic [31:0] cfg_r;
  logic [7:0] rise_cnt_r;
  logic clean_r;
  wire logic wr_cfg = wb_ack_o && wb_we_i && wb_adr_i == pvc_pkg::ADR_CFG;
  wire logic unmapped = wb_adr_i[1:0] != 2'h0 || wb_adr_i > pvc_pkg::ADR_STAT;
  wire logic [31:0] bm = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire logic plain = !cfg_r[pvc_pkg::B_SLAVE] && !cfg_r[pvc_pkg::B_HI] && !cfg_r[pvc_pkg::B_ISDN];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= pvc_pkg::CFG_RST;
    end else if (wr_cfg) begin
      cfg_r <= ((wb_dat_i & bm) | (cfg_r & ~bm)) & pvc_pkg::CFG_MASK;
    end
  end
  // A pulse is only judged when no register write landed during it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_cnt_r <= 8'h00;
      clean_r <= 1'b0;
    end else begin
      rise_cnt_r <= $rose(pcm_sync_o) ? 8'h00 : rise_cnt_r + 8'($rose(pcm_clk_o));
      clean_r <= $rose(pcm_sync_o) || (clean_r && !(wb_ack_o && wb_we_i));
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_ack_one_wait: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
    else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  a_cfg_readback: assert property (wb_ack_o && !wb_we_i && wb_adr_i == pvc_pkg::ADR_CFG
    |-> wb_dat_o == cfg_r) else $error("config readback wrong");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && unmapped |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_role_pins: assert property (wr_cfg && wb_sel_i[0] |=> ##1
    pcm_clk_oe_n == $past(wb_dat_i[1], 2) && pcm_sync_oe_n == pcm_clk_oe_n)
    else $error("role pins wrong");
  a_sync_length: assert property ($fell(pcm_sync_o) && clean_r && plain
    |-> rise_cnt_r == (cfg_r[pvc_pkg::B_SHORT] ? 8'h01 : pvc_pkg::SYNC_LONG))
    else $error("sync length wrong");
  a_mute_quiet: assert property (cfg_r[10] && $past(cfg_r[10]) |-> !$rose(pcm_out))
    else $error("muted output rose");
  a_release_gate: assert property ($rose(pcm_out_oe_n) |-> cfg_r[pvc_pkg::B_REL])
    else $error("release while disabled");
  a_hold_sync: assert property (cfg_r[8] && $past(cfg_r[8]) && !cfg_r[1] |-> !$rose(pcm_sync_o))
    else $error("held sync rose");
endmodule : pvc_chk
bind pvc_port pvc_chk i_chk (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pcm_clk_o(pcm_clk_o), .pcm_clk_oe_n(pcm_clk_oe_n),
  .pcm_sync_o(pcm_sync_o), .pcm_sync_oe_n(pcm_sync_oe_n), .pcm_out(pcm_out),
  .pcm_out_oe_n(pcm_out_oe_n));
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam logic [15:0] SMP = 16'h9ad3;
  localparam logic [31:0] CF [12] = '{32'h0, 32'h10, 32'h0800_0020, 32'h1000_0000, 32'h1000_0010,
    32'h1800_0020, 32'h4, 32'h0800_0400, 32'h0780_0000, 32'h200, 32'h0800_0040, 32'h0800_00c0};
  logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, q, dat_o;
  logic slave_m = 1'b0, short_m = 1'b0, pc = 1'b0;
  logic ack, clk_o, clk_oe_n, sync_o, sync_oe_n, pout, pout_oe_n, m_clk, m_sync, m_din;
  logic [15:0] word;
  logic [7:0] frames;
  logic [1:0] rc [3] = '{pvc_pkg::RATE_128, 2'h0, pvc_pkg::RATE_512};
  logic [15:0] kh [3] = '{pvc_pkg::KHZ_128, pvc_pkg::KHZ_256, pvc_pkg::KHZ_512};
  int errors = 0, checks_done = 0, r, h, e;
  wire logic clk_ln = clk_oe_n ? m_clk : clk_o;
  wire logic sync_ln = sync_oe_n ? m_sync : sync_o;
  always #4 clk = ~clk;
  pvc_port i_dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .pcm_clk_i(clk_ln), .pcm_clk_o(clk_o), .pcm_clk_oe_n(clk_oe_n), .pcm_sync_i(sync_ln),
    .pcm_sync_o(sync_o), .pcm_sync_oe_n(sync_oe_n), .pcm_in(m_din), .pcm_out(pout),
    .pcm_out_oe_n(pout_oe_n));
  pvc_codec i_codec (.clk(clk), .rst_n(rst_n), .slave_mode(slave_m), .short_mode(short_m),
    .pat(SMP), .dut_clk(clk_o), .dut_sync(sync_o), .dut_out(pout), .dut_out_oe_n(pout_oe_n),
    .bclk_o(m_clk), .sync_o(m_sync), .din_o(m_din), .word_o(word), .frames_o(frames));
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up
  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      errors++;
      wrap_up();
    end
  endtask : tmo
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Ack and read data are taken at the rising edge where ack is seen high, before that
  // edge's updates land, and the request is dropped at that same edge.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s, output logic [31:0] rq);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    tmo(n, 40);
    rq = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, 4'hf, x);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] x);
    xfer(1'b0, a, 32'h0, 4'hf, x);
  endtask : rd
  task automatic wait_frames(input int k);
    logic [7:0] f0;
    int n;
    f0 = frames;
    n = 0;
    while (8'(frames - f0) < k && n < 60000) begin
      @(posedge clk);
      n++;
    end
    tmo(n, 60000);
  endtask : wait_frames
  function automatic logic [15:0] slot(input logic [31:0] c);
    logic [15:0] w;
    logic [15:0] v;
    case (c[28:27])
      pvc_pkg::FMT_13: w = c[4] ? {{3{SMP[12]}}, SMP[12:0]} : {SMP[12:0], 3'h5};
      pvc_pkg::FMT_16: w = SMP;
      pvc_pkg::FMT_8: w = c[4] ? {{8{SMP[7]}}, SMP[7:0]} : {SMP[7:0], 8'h00};
      default: w = {SMP[7:0], 8'h00};
    endcase
    for (int i = 0; i < 16; i++) v[i] = w[15 - i];
    if (c[5]) w = (c[28:27] == 2'h3) ? {v[7:0], 8'h00} : v;
    if (c[10]) w = 16'h0;
    if (c[9]) w = SMP;
    return w;
  endfunction : slot
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(pvc_pkg::ADR_CFG, q);
    chk(q, pvc_pkg::CFG_RST);
    rd(pvc_pkg::ADR_SYN, q);
    chk(q, pvc_pkg::SYN_RST);
    chk({30'h0, clk_oe_n, sync_oe_n}, 32'h0);
    wr(pvc_pkg::ADR_CFG, 32'hffff_ffff);
    xfer(1'b1, pvc_pkg::ADR_CFG, 32'h0, 4'h2, q);
    rd(pvc_pkg::ADR_CFG, q);
    chk(q, pvc_pkg::CFG_MASK & 32'hffff_00ff);
    wr(pvc_pkg::ADR_SYN, 32'hffff_ffff);
    rd(pvc_pkg::ADR_SYN, q);
    chk(q, pvc_pkg::SYN_MASK);
    wr(8'h40, 32'hffff_ffff);
    rd(8'h40, q);
    chk(q, 32'h0);
    wr(pvc_pkg::ADR_SYN, pvc_pkg::SYN_RST);
    wr(pvc_pkg::ADR_GAIN, 32'h5);
    wr(pvc_pkg::ADR_TX, {16'h0, SMP});
    rd(pvc_pkg::ADR_GAIN, q);
    chk(q, 32'h5);
    rd(pvc_pkg::ADR_TX, q);
    chk(q, {16'h0, SMP});
    $display("test registers done");
    for (int i = 0; i < 3; i++) begin
      wr(pvc_pkg::ADR_CFG, {9'h0, rc[i], 21'h000100});
      repeat (600) @(negedge clk);
      r = 0;
      h = 0;
      repeat (2000) begin
        @(negedge clk);
        r += int'(clk_o && !pc);
        h += int'(sync_o);
        pc = clk_o;
      end
      e = int'(kh[i]) * 2000 / 125000;
      chk(32'(r > e - 2 && r < e + 2), 32'h1);
      chk(32'(h), 32'h0);
    end
    $display("test rates done");
    wr(pvc_pkg::ADR_CFG, pvc_pkg::CFG_RST);
    wait_frames(2);
    chk({16'h0, word}, {16'h0, slot(pvc_pkg::CFG_RST)});
    $display("test master done");
    slave_m <= 1'b1;
    foreach (CF[i]) begin
      short_m <= CF[i][2];
      wr(pvc_pkg::ADR_CFG, CF[i] | 32'h0080_0002);
      wait_frames(2);
      chk({16'h0, word}, {16'h0, slot(CF[i])});
      if (CF[i][6]) begin
        repeat (12) @(posedge clk);
        chk({31'h0, pout_oe_n}, 32'h1);
      end
    end
    rd(pvc_pkg::ADR_RX, q);
    chk(q, {16'h0, SMP});
    $display("test slave done");
    wrap_up();
  end
endmodule : tb
`default_nettype wire
